// file: design/occ_pkg.sv
// Package with register map, field layout and reset values of the calibration bank.
package occ_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_OFS_HI = 8'h84;
  localparam logic [7:0] IDX_OFS_LO = 8'h85;
  localparam logic [7:0] IDX_GAIN = 8'h86;
  localparam logic [7:0] IDX_OCC_CFG = 8'h87;
  localparam logic [7:0] IDX_STATUS = 8'h88;
  localparam logic [7:0] IDX_MASK = 8'h89;
  localparam logic [ADDR_W-1:0] ADDR_OFS_HI = {IDX_OFS_HI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OFS_LO = {IDX_OFS_LO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GAIN = {IDX_GAIN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OCC_CFG = {IDX_OCC_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
  // Field positions.
  localparam int OFS_LO_LSB = 8;
  localparam int OFS_LO_MSB = 15;
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_POL_BIT = 14;
  localparam int CFG_RSV_BIT = 13;
  localparam int CFG_CNT_MSB = 12;
  localparam int CFG_CNT_LSB = 8;
  localparam int STAT_HI_BIT = 0;
  localparam int STAT_LO_BIT = 1;
  localparam int STAT_W = 2;
  localparam int CNT_W = 5;
  localparam int SAMPLE_W = 24;
  localparam int GAIN_FRAC = 16;
  // Reset values.
  localparam logic [15:0] RST_OFS_HI = 16'h0000;
  localparam logic [7:0] RST_OFS_LO = 8'h00;
  localparam logic [15:0] RST_GAIN = 16'h0000;
  localparam logic [7:0] RST_OCC_CFG = 8'h00;
  localparam logic [STAT_W-1:0] RST_STATUS = 2'h0;
  localparam logic [STAT_W-1:0] RST_MASK = 2'h0;
  // Unity gain in the same fixed-point scale as the correction code.
  localparam logic signed [17:0] GAIN_UNITY = 18'sh10000;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 24'sh7FFFFF;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 24'sh800000;
endpackage

// file: design/occ_cfg_if.sv
// Interface carrying the comparator settings from the register bank to the trip counters.
`timescale 1ns/100ps
interface occ_cfg_if;
  logic active;
  logic [occ_pkg::CNT_W-1:0] count_code;
  modport bank (output active, output count_code);
  modport counter (input active, input count_code);
endinterface

// file: design/occ_trip_counter.sv
// Consecutive-sample trip counter for one threshold of the overcurrent comparator.
`timescale 1ns/100ps
module occ_trip_counter (
  input wire logic clk,
  input wire logic rst,
  occ_cfg_if.counter cfg,
  input wire logic sample_valid,
  input wire logic exceed,
  output logic tripped
);
  logic [occ_pkg::CNT_W:0] run_r;
  logic [occ_pkg::CNT_W:0] run_nxt;
  logic [occ_pkg::CNT_W:0] target;
  logic tripped_r;
  logic tripped_nxt;

  // Code zero asks for a single sample, so the target is the code plus one.
  assign target = {1'b0, cfg.count_code} + 6'h01;
  // The run saturates at the target so a long fault cannot wrap the counter.
  assign run_nxt = (run_r < target) ? run_r + 6'h01 : run_r;
  // No hysteresis: one sample back inside the threshold clears the flag.
  always_comb begin
    tripped_nxt = tripped_r;
    if (!cfg.active) begin
      tripped_nxt = 1'b0;
    end else if (sample_valid) begin
      tripped_nxt = exceed && (run_nxt >= target);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !cfg.active) begin
      run_r <= '0;
    end else if (sample_valid) begin
      run_r <= exceed ? run_nxt : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tripped_r <= 1'b0;
    end else begin
      tripped_r <= tripped_nxt;
    end
  end

  assign tripped = tripped_r;

  trip_needs_run_a: assert property (@(posedge clk) disable iff (rst)
    $rose(tripped) |-> $past(run_nxt) >= $past(target))
    else $error("flag tripped before the consecutive count was reached");
endmodule

// file: design/occ_cal_regs.sv
// Calibration and overcurrent-comparator register bank of current converter channel A.
// How it works
// - The upper sixteen bits of the signed 24-bit offset correction are a read/write register.
// - The low eight offset bits sit in bits 15:8 of a second register whose low byte reads zero.
// - The offset is subtracted in input-code units before the gain, so its weight follows the selected gain.
// - The signed 16-bit gain correction is a read/write register that resets to zero.
// - The applied gain is one plus the signed code times two to the minus sixteen.
// - The fast-filter comparator halts with the converter, since converter_enable gates it.
// - The comparator runs only with its enable bit set and the converter enabled.
// - The polarity bit sets the fault pin level, low on a fault when zero, fault being any flag.
// - A flag trips after code plus one consecutive exceeding samples, with no hysteresis.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module occ_cal_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [occ_pkg::ADDR_W-1:0] paddr,
  input wire logic [occ_pkg::DATA_W-1:0] pwdata,
  output logic [occ_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic converter_enable,
  input wire logic filter_valid,
  input wire logic signed [occ_pkg::SAMPLE_W-1:0] filter_data,
  input wire logic signed [occ_pkg::SAMPLE_W-1:0] high_threshold,
  input wire logic signed [occ_pkg::SAMPLE_W-1:0] low_threshold,
  input wire logic raw_valid,
  input wire logic signed [occ_pkg::SAMPLE_W-1:0] raw_data,
  output logic corr_valid,
  output logic signed [occ_pkg::SAMPLE_W-1:0] corr_data,
  output logic [occ_pkg::SAMPLE_W-1:0] offset_correction_value,
  output logic [15:0] gain_correction_value,
  output logic high_threshold_flag,
  output logic low_threshold_flag,
  output logic fault_out,
  output logic irq
);
  // Clamps a wider signed result into the sample range.
  function automatic logic signed [occ_pkg::SAMPLE_W-1:0] sat_sample(
    input logic signed [26:0] value
  );
    if (value > 27'(occ_pkg::SAMPLE_MAX)) begin
      return occ_pkg::SAMPLE_MAX;
    end else if (value < 27'(occ_pkg::SAMPLE_MIN)) begin
      return occ_pkg::SAMPLE_MIN;
    end
    return value[occ_pkg::SAMPLE_W-1:0];
  endfunction

  logic [15:0] offset_hi_r;
  logic [7:0] offset_lo_r;
  logic [15:0] gain_r;
  logic [7:0] occ_cfg_r;
  logic [occ_pkg::STAT_W-1:0] status_r;
  logic [occ_pkg::STAT_W-1:0] status_nxt;
  logic [occ_pkg::STAT_W-1:0] mask_r;
  logic [occ_pkg::DATA_W-1:0] prdata_r;
  logic high_flag_q_r;
  logic low_flag_q_r;
  logic corr_valid_r;
  logic signed [occ_pkg::SAMPLE_W-1:0] corr_data_r;

  // Bus decode.
  wire setup_phase = psel && !penable;
  wire access_phase = psel && penable;
  wire hit_ofs_hi = (paddr == occ_pkg::ADDR_OFS_HI);
  wire hit_ofs_lo = (paddr == occ_pkg::ADDR_OFS_LO);
  wire hit_gain = (paddr == occ_pkg::ADDR_GAIN);
  wire hit_cfg = (paddr == occ_pkg::ADDR_OCC_CFG);
  wire hit_status = (paddr == occ_pkg::ADDR_STATUS);
  wire hit_mask = (paddr == occ_pkg::ADDR_MASK);
  wire addr_hit = hit_ofs_hi || hit_ofs_lo || hit_gain || hit_cfg || hit_status || hit_mask;
  wire wr_en = access_phase && pwrite && addr_hit;
  wire wr_ofs_hi = wr_en && hit_ofs_hi;
  wire wr_ofs_lo = wr_en && hit_ofs_lo;
  wire wr_gain = wr_en && hit_gain;
  wire wr_cfg = wr_en && hit_cfg;
  wire wr_status = wr_en && hit_status;
  wire wr_mask = wr_en && hit_mask;

  // Every transfer completes in its first access cycle.
  assign pready = access_phase;
  assign pslverr = access_phase && !addr_hit;

  // Configuration fields.
  wire occ_en = occ_cfg_r[occ_pkg::CFG_EN_BIT - 8];
  wire occ_pol = occ_cfg_r[occ_pkg::CFG_POL_BIT - 8];
  wire [occ_pkg::CNT_W-1:0] occ_count = occ_cfg_r[occ_pkg::CFG_CNT_MSB-8:occ_pkg::CFG_CNT_LSB-8];

  // Read data mux; unlisted bits read as zero.
  logic [occ_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_ofs_hi) begin
      rd_mux[15:0] = offset_hi_r;
    end else if (hit_ofs_lo) begin
      rd_mux[occ_pkg::OFS_LO_MSB:occ_pkg::OFS_LO_LSB] = offset_lo_r;
    end else if (hit_gain) begin
      rd_mux[15:0] = gain_r;
    end else if (hit_cfg) begin
      rd_mux[15:8] = occ_cfg_r;
    end else if (hit_status) begin
      rd_mux[occ_pkg::STAT_W-1:0] = status_r;
    end else if (hit_mask) begin
      rd_mux[occ_pkg::STAT_W-1:0] = mask_r;
    end
  end

  // Read data is captured in the setup cycle so that prdata comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end
  assign prdata = prdata_r;

  // Calibration registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      offset_hi_r <= occ_pkg::RST_OFS_HI;
      offset_lo_r <= occ_pkg::RST_OFS_LO;
      gain_r <= occ_pkg::RST_GAIN;
    end else begin
      if (wr_ofs_hi) begin
        offset_hi_r <= pwdata[15:0];
      end
      if (wr_ofs_lo) begin
        offset_lo_r <= pwdata[occ_pkg::OFS_LO_MSB:occ_pkg::OFS_LO_LSB];
      end
      if (wr_gain) begin
        gain_r <= pwdata[15:0];
      end
    end
  end

  // The reserved bit 13 is stored like the others; software is expected to write zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      occ_cfg_r <= occ_pkg::RST_OCC_CFG;
    end else if (wr_cfg) begin
      occ_cfg_r <= pwdata[15:8];
    end
  end

  assign offset_correction_value = {offset_hi_r, offset_lo_r};
  assign gain_correction_value = gain_r;

  // Correction datapath: subtract offset, then scale by the gain factor.
  wire signed [occ_pkg::SAMPLE_W:0] diff =
    (occ_pkg::SAMPLE_W+1)'(raw_data) - (occ_pkg::SAMPLE_W+1)'($signed(offset_correction_value));
  wire signed [17:0] gain_factor = occ_pkg::GAIN_UNITY + 18'($signed(gain_r));
  wire signed [42:0] product = 43'(diff) * 43'(gain_factor);
  wire signed [26:0] scaled = product[42:occ_pkg::GAIN_FRAC];

  always_ff @(posedge clk) begin
    if (rst) begin
      corr_valid_r <= 1'b0;
      corr_data_r <= '0;
    end else begin
      corr_valid_r <= raw_valid;
      if (raw_valid) begin
        corr_data_r <= sat_sample(scaled);
      end
    end
  end
  assign corr_valid = corr_valid_r;
  assign corr_data = corr_data_r;

  // Overcurrent comparator. The comparator is gated by converter_enable,
  // so detection stops while the converter is disabled.
  occ_cfg_if cfg_bus ();
  assign cfg_bus.active = occ_en && converter_enable;
  assign cfg_bus.count_code = occ_count;

  wire high_exceed = filter_data > high_threshold;
  wire low_exceed = filter_data < low_threshold;

  occ_trip_counter u_high_trip (
    .clk(clk),
    .rst(rst),
    .cfg(cfg_bus),
    .sample_valid(filter_valid),
    .exceed(high_exceed),
    .tripped(high_threshold_flag)
  );

  occ_trip_counter u_low_trip (
    .clk(clk),
    .rst(rst),
    .cfg(cfg_bus),
    .sample_valid(filter_valid),
    .exceed(low_exceed),
    .tripped(low_threshold_flag)
  );

  wire fault_any = high_threshold_flag || low_threshold_flag;
  // Polarity zero drives low on a fault; idle level is the opposite.
  assign fault_out = occ_pol ? fault_any : !fault_any;

  // Interrupt status: a trip sets its bit, a written one clears it, and a set wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      high_flag_q_r <= 1'b0;
      low_flag_q_r <= 1'b0;
    end else begin
      high_flag_q_r <= high_threshold_flag;
      low_flag_q_r <= low_threshold_flag;
    end
  end
  wire high_event = high_threshold_flag && !high_flag_q_r;
  wire low_event = low_threshold_flag && !low_flag_q_r;
  wire [occ_pkg::STAT_W-1:0] stat_set = {low_event, high_event};
  wire [occ_pkg::STAT_W-1:0] stat_clr = wr_status ? pwdata[occ_pkg::STAT_W-1:0] : '0;
  assign status_nxt = (status_r & ~stat_clr) | stat_set;

  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= occ_pkg::RST_STATUS;
      mask_r <= occ_pkg::RST_MASK;
    end else begin
      status_r <= status_nxt;
      if (wr_mask) begin
        mask_r <= pwdata[occ_pkg::STAT_W-1:0];
      end
    end
  end
  assign irq = |(status_r & mask_r);

  // Checks.
  ofs_hi_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_ofs_hi |=> offset_correction_value[23:8] == $past(pwdata[15:0]))
    else $error("upper offset bits did not take the written value");

  ofs_lo_read_a: assert property (@(posedge clk) disable iff (rst)
    access_phase && !pwrite && hit_ofs_lo |-> prdata[7:0] == 8'h00
      && prdata[15:8] == offset_correction_value[7:0] && prdata[31:16] == 16'h0000)
    else $error("low offset register read back wrongly");

  gain_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_gain ##1 (!wr_gain)[*2] |-> gain_correction_value == $past(pwdata[15:0], 2))
    else $error("gain correction did not hold the written value");

  unity_path_a: assert property (@(posedge clk) disable iff (rst)
    raw_valid && gain_r == 16'h0000 |=> corr_data == $past(sat_sample(27'(diff))))
    else $error("offset subtraction at unity gain is wrong");

  half_gain_a: assert property (@(posedge clk) disable iff (rst)
    raw_valid && gain_r == 16'h8000 && offset_correction_value == 24'h000000
      && raw_data == 24'sh000100 |=> corr_data == 24'sh000080)
    else $error("most negative gain code is not one half");

  cmp_disabled_a: assert property (@(posedge clk) disable iff (rst)
    !(occ_en && converter_enable) |=> !high_threshold_flag && !low_threshold_flag)
    else $error("flag active while the comparator is disabled");

  fault_pin_a: assert property (@(posedge clk) disable iff (rst)
    fault_any && !occ_pol |-> !fault_out)
    else $error("fault not driven low with polarity zero");

  single_trip_a: assert property (@(posedge clk) disable iff (rst)
    cfg_bus.active && occ_count == 5'h00 && filter_valid && high_exceed
      |=> high_threshold_flag)
    else $error("count code zero did not trip on one sample");

  no_hyst_a: assert property (@(posedge clk) disable iff (rst)
    filter_valid && !high_exceed |=> !high_threshold_flag)
    else $error("high flag held after sample fell back");

  cfg_read_a: assert property (@(posedge clk) disable iff (rst)
    access_phase && !pwrite && hit_cfg |-> prdata[7:0] == 8'h00 && prdata[15:8] == occ_cfg_r)
    else $error("comparator word read back wrongly");

  status_set_a: assert property (@(posedge clk) disable iff (rst)
    high_event |=> status_r[occ_pkg::STAT_HI_BIT] ##0 (irq == mask_r[occ_pkg::STAT_HI_BIT]
      || status_r[occ_pkg::STAT_LO_BIT]))
    else $error("trip event lost or interrupt wrong");

  unmapped_a: assert property (@(posedge clk) disable iff (rst)
    access_phase && !addr_hit |-> pslverr && pready)
    else $error("unmapped access not answered with an error");

  ofs_lo_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_ofs_lo |=> offset_correction_value[7:0]
      == $past(pwdata[occ_pkg::OFS_LO_MSB:occ_pkg::OFS_LO_LSB]))
    else $error("low offset bits did not take the written value");

  ofs_hi_read_a: assert property (@(posedge clk) disable iff (rst)
    access_phase && !pwrite && hit_ofs_hi |->
      prdata == {16'h0000, offset_correction_value[23:8]})
    else $error("upper offset register read back wrongly");

  gain_read_a: assert property (@(posedge clk) disable iff (rst)
    access_phase && !pwrite && hit_gain |-> prdata == {16'h0000, gain_correction_value})
    else $error("gain correction register read back wrongly");

  cfg_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_cfg |=> occ_cfg_r == $past(pwdata[15:8]))
    else $error("comparator word did not take the written value");

  corr_follow_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> corr_valid == $past(raw_valid))
    else $error("corrected sample strobe not one cycle after the raw strobe");

  fault_pol_high_a: assert property (@(posedge clk) disable iff (rst)
    occ_pol |-> fault_out == fault_any)
    else $error("fault pin wrong with polarity one");

  fault_idle_a: assert property (@(posedge clk) disable iff (rst)
    !occ_pol && !fault_any |-> fault_out)
    else $error("fault pin not idle high with polarity zero");

  low_single_trip_a: assert property (@(posedge clk) disable iff (rst)
    cfg_bus.active && occ_count == 5'h00 && filter_valid && low_exceed
      |=> low_threshold_flag)
    else $error("count code zero did not trip the low flag on one sample");

  low_no_hyst_a: assert property (@(posedge clk) disable iff (rst)
    filter_valid && !low_exceed |=> !low_threshold_flag)
    else $error("low flag held after sample fell back");

  hold_invalid_a: assert property (@(posedge clk) disable iff (rst)
    cfg_bus.active && !filter_valid |=> $stable(high_threshold_flag))
    else $error("high flag changed without a filter sample");

  status_clear_a: assert property (@(posedge clk) disable iff (rst)
    wr_status && pwdata[occ_pkg::STAT_HI_BIT] && !high_event
      |=> !status_r[occ_pkg::STAT_HI_BIT])
    else $error("written one did not clear the high trip status");

  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    wr_status && pwdata[occ_pkg::STAT_HI_BIT] && high_event
      |=> status_r[occ_pkg::STAT_HI_BIT])
    else $error("clear won over a trip event in the same cycle");

  mask_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_mask |=> mask_r == $past(pwdata[occ_pkg::STAT_W-1:0]))
    else $error("mask did not take the written value");

  refused_write_a: assert property (@(posedge clk) disable iff (rst)
    access_phase && pwrite && !addr_hit
      |=> $stable(offset_correction_value) && $stable(gain_correction_value))
    else $error("unmapped write changed a calibration register");

  status_clear_c: cover property (@(posedge clk) disable iff (rst) wr_status && |status_r);
  high_trip_c: cover property (@(posedge clk) disable iff (rst) $rose(high_threshold_flag));
  low_trip_c: cover property (@(posedge clk) disable iff (rst) $rose(low_threshold_flag));
  irq_c: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  multi_count_c: cover property (@(posedge clk) disable iff (rst)
    occ_count > 5'h02 && $rose(low_threshold_flag));
endmodule

// file: test/occ_apb_host.sv
// Host-side APB master model that reaches the calibration register bank.
`timescale 1ns/100ps
module occ_apb_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [occ_pkg::ADDR_W-1:0] paddr,
  output logic [occ_pkg::DATA_W-1:0] pwdata,
  input wire logic [occ_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // Released address and data show the inverse so no stale value can be mistaken for a request.
  task automatic xfer(input logic wr, input logic [occ_pkg::ADDR_W-1:0] a,
                      input logic [occ_pkg::DATA_W-1:0] d, output logic [occ_pkg::DATA_W-1:0] q,
                      output logic err, output logic ok);
    int n;
    ok = 1'b0;
    q = '0;
    err = 1'b0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        q = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// file: test/occ_cal_regs_test.sv
// Self-checking testbench of the calibration and overcurrent register bank.
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module occ_cal_regs_test;
  localparam logic [9:0] A_HI = occ_pkg::ADDR_OFS_HI;
  localparam logic [9:0] A_LO = occ_pkg::ADDR_OFS_LO;
  localparam logic [9:0] A_GN = occ_pkg::ADDR_GAIN;
  localparam logic [9:0] A_CF = occ_pkg::ADDR_OCC_CFG;
  localparam logic [9:0] A_ST = occ_pkg::ADDR_STATUS;
  localparam logic [9:0] A_MK = occ_pkg::ADDR_MASK;
  logic clk = 1'b0;
  logic rst, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic converter_enable, filter_valid, raw_valid, corr_valid;
  logic signed [23:0] filter_data, high_threshold, low_threshold, raw_data, corr_data;
  logic [23:0] offset_correction_value;
  logic [15:0] gain_correction_value;
  logic high_threshold_flag, low_threshold_flag, fault_out, irq;
  int num_errors = 0;
  int cmp_count = 0;
  logic signed [23:0] tr [4] = '{24'sh001000, 24'sh000100, 24'sh7FF000, 24'sh800000};
  logic signed [23:0] to [4] = '{24'sh000000, 24'sh000000, -24'sh001000, 24'sh000001};
  logic [15:0] tg [4] = '{16'h0000, 16'h8000, 16'h7FFF, 16'h0001};

  always #5 clk = ~clk;

  occ_cal_regs i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .converter_enable(converter_enable), .filter_valid(filter_valid),
    .filter_data(filter_data), .high_threshold(high_threshold), .low_threshold(low_threshold),
    .raw_valid(raw_valid), .raw_data(raw_data), .corr_valid(corr_valid),
    .corr_data(corr_data), .offset_correction_value(offset_correction_value),
    .gain_correction_value(gain_correction_value), .high_threshold_flag(high_threshold_flag),
    .low_threshold_flag(low_threshold_flag), .fault_out(fault_out), .irq(irq));

  occ_apb_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic e);
    logic [31:0] q;
    logic s, ok;
    i_host.xfer(1'b1, a, {16'h0000, d}, q, s, ok);
    `CHK(ok, 1'b1)
    if (!ok) complete_run();
    `CHK(s, e)
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] x, input logic e);
    logic [31:0] q;
    logic s, ok;
    i_host.xfer(1'b0, a, 32'h0000_0000, q, s, ok);
    `CHK(ok, 1'b1)
    if (!ok) complete_run();
    `CHK(s, e)
    `CHK(q, x)
  endtask

  // Wide arithmetic keeps the product exact before the saturating cut to 24 bits.
  function automatic logic signed [23:0] ex(input logic signed [23:0] r, o,
                                            input logic signed [15:0] g);
    longint t;
    t = ((longint'(r) - longint'(o)) * (65536 + longint'(g))) >>> 16;
    if (t > 8388607) t = 8388607;
    if (t < -8388608) t = -8388608;
    return t[23:0];
  endfunction

  task automatic cs(input logic signed [23:0] r, input logic signed [23:0] x);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_data <= r;
    @(posedge clk);
    raw_valid <= 1'b0;
    #1;
    `CHK(corr_valid, 1'b1)
    `CHK(corr_data, x)
  endtask

  task automatic fs(input logic signed [23:0] d);
    @(posedge clk);
    filter_valid <= 1'b1;
    filter_data <= d;
    @(posedge clk);
    filter_valid <= 1'b0;
    #1;
  endtask

  initial begin
    rst = 1'b1;
    converter_enable = 1'b0;
    filter_valid = 1'b0;
    filter_data = '0;
    high_threshold = 24'sh000064;
    low_threshold = -24'sh000064;
    raw_valid = 1'b0;
    raw_data = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK(fault_out, 1'b1)
    rd(A_HI, 32'h0000_0000, 1'b0);
    rd(A_LO, 32'h0000_0000, 1'b0);
    rd(A_GN, 32'h0000_0000, 1'b0);
    rd(A_CF, 32'h0000_0000, 1'b0);
    rd(A_ST, 32'h0000_0000, 1'b0);
    rd(A_MK, 32'h0000_0000, 1'b0);
    $display("test reset values done");
    wr(A_HI, 16'hA5C3, 1'b0);
    rd(A_HI, 32'h0000_A5C3, 1'b0);
    wr(A_LO, 16'hFFFF, 1'b0);
    rd(A_LO, 32'h0000_FF00, 1'b0);
    `CHK(offset_correction_value, 24'hA5C3FF)
    wr(A_GN, 16'h8001, 1'b0);
    rd(A_GN, 32'h0000_8001, 1'b0);
    `CHK(gain_correction_value, 16'h8001)
    wr(A_CF, 16'hFFFF, 1'b0);
    rd(A_CF, 32'h0000_FF00, 1'b0);
    wr(10'h3FC, 16'h1234, 1'b1);
    rd(10'h3FC, 32'h0000_0000, 1'b1);
    wr(A_CF, 16'h0000, 1'b0);
    $display("test register access done");
    for (int i = 0; i < 4; i++) begin
      wr(A_HI, to[i][23:8], 1'b0);
      wr(A_LO, {to[i][7:0], 8'h00}, 1'b0);
      wr(A_GN, tg[i], 1'b0);
      cs(tr[i], ex(tr[i], to[i], tg[i]));
    end
    $display("test correction done");
    // Software keeps the converter running so the comparator can act.
    @(posedge clk);
    converter_enable <= 1'b1;
    wr(A_CF, 16'h8200, 1'b0);
    fs(24'sh0000C8);
    fs(24'sh0000C8);
    `CHK(high_threshold_flag, 1'b0)
    fs(24'sh0000C8);
    `CHK(high_threshold_flag, 1'b1)
    `CHK(fault_out, 1'b0)
    fs(24'sh000064);
    `CHK(high_threshold_flag, 1'b0)
    `CHK(fault_out, 1'b1)
    wr(A_CF, 16'hC000, 1'b0);
    fs(-24'sh0000C8);
    `CHK(low_threshold_flag, 1'b1)
    `CHK(fault_out, 1'b1)
    fs(24'sh000000);
    `CHK(fault_out, 1'b0)
    wr(A_CF, 16'h0000, 1'b0);
    fs(24'sh0000C8);
    `CHK(high_threshold_flag, 1'b0)
    @(posedge clk);
    converter_enable <= 1'b0;
    wr(A_CF, 16'h8000, 1'b0);
    fs(24'sh0000C8);
    `CHK(high_threshold_flag, 1'b0)
    $display("test comparator done");
    // Both trips of the comparator test are still latched; clear them first.
    rd(A_ST, 32'h0000_0003, 1'b0);
    wr(A_ST, 16'h0003, 1'b0);
    #1;
    `CHK(irq, 1'b0)
    @(posedge clk);
    converter_enable <= 1'b1;
    wr(A_MK, 16'h0001, 1'b0);
    fs(24'sh0000C8);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    rd(A_ST, 32'h0000_0001, 1'b0);
    wr(A_ST, 16'h0001, 1'b0);
    rd(A_ST, 32'h0000_0000, 1'b0);
    `CHK(irq, 1'b0)
    fs(24'sh000000);
    fs(-24'sh0000C8);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    rd(A_ST, 32'h0000_0002, 1'b0);
    wr(A_MK, 16'h0003, 1'b0);
    #1;
    `CHK(irq, 1'b1)
    wr(A_ST, 16'h0002, 1'b0);
    #1;
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    complete_run();
  end
endmodule
